// ==== loader_params.svh ====
// constants of the serial boot loader link
`ifndef LOADER_PARAMS_SVH
`define LOADER_PARAMS_SVH
`define CLK_HZ       25000000
`define LINK_BAUD    230400
`define HOST_DIV     (`CLK_HZ / `LINK_BAUD)
`define TIMEOUT_S    5
`define TIMEOUT_CYC  (`TIMEOUT_S * `CLK_HZ)
`define DIV_MIN      16'h0008
`define DIV_MAX      16'h0FFF
`define PROBE_BYTE   8'h86
`define CMD_RAM      8'h10
`define CMD_SUM      8'h20
`define CMD_INFO     8'h30
`define CMD_ERASE    8'h40
`define CMD_PROT     8'h60
`define ACK_OK_LO    4'h0
`define ACK_BAD_LO   4'h1
`define ACK_PROT_LO  4'h6
`define ACK_RXE_LO   4'h8
`define PWD_LEN      16'h000C
`define HDR_LEN      16'h0006
`define RAM_LO       32'h00001000
`define RAM_HI       32'h00001DFF
`define PROT_RST     2'h0
`define PROT_ALL     2'h3
`endif

// ==== loader_pkg.sv ====
// state types for the two ends of the boot loader link, one enum for each end
package loader_pkg;
  typedef enum logic [3:0] {
    D_PROBE = 4'h0,
    D_MEAS  = 4'h1,
    D_TAIL  = 4'h2,
    D_ARM   = 4'h3,
    D_HALT  = 4'h4,
    D_CMD   = 4'h5,
    D_PWD   = 4'h6,
    D_HDR   = 4'h7,
    D_DATA  = 4'h8,
    D_RUN   = 4'h9
  } dev_state_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SEND = 2'h1,
    H_WAIT = 2'h2
  } host_state_t;
endpackage

// ==== loader_link_if.sv ====
// serial link between boot controller and device
`timescale 1ns/1ns
interface loader_link_if;
  logic ctl_txd;
  logic dev_txd;
  modport device (input ctl_txd, output dev_txd);
  modport controller (output ctl_txd, input dev_txd);
endinterface

// ==== uart_byte_port.sv ====
// byte-wide asynchronous serial receiver and transmitter
`timescale 1ns/1ns
module uart_byte_port (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] div,
  input  wire logic        rx_en,
  input  wire logic        rxd,
  output logic             rxd_s,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             rx_err,
  input  wire logic        tx_start,
  input  wire logic [7:0]  tx_data,
  output logic             tx_busy,
  output logic             txd
);
  logic        meta_q;
  logic        ract_q;
  logic [15:0] rcnt_q;
  logic [3:0]  rbit_q;
  logic [15:0] tcnt_q;
  logic [3:0]  tbit_q;
  logic [8:0]  tsh_q;

  // two-stage synchroniser on the line
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      rxd_s  <= 1'b1;
    end else begin
      meta_q <= rxd;
      rxd_s  <= meta_q;
    end
  end

  // receiver: start, eight data bits lsb first, stop, sampled mid-bit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ract_q   <= 1'b0;
      rcnt_q   <= 16'h0000;
      rbit_q   <= 4'h0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      rx_err   <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!ract_q) begin
        if (rx_en && !rxd_s) begin
          ract_q <= 1'b1;
          rcnt_q <= div >> 1;
          rbit_q <= 4'h0;
        end
      end else if (rcnt_q != 16'h0000) begin
        rcnt_q <= rcnt_q - 16'h0001;
      end else begin
        rcnt_q <= div - 16'h0001;
        rbit_q <= rbit_q + 4'h1;
        if (rbit_q == 4'h0 && rxd_s) begin
          ract_q <= 1'b0; // glitch, not a start bit
        end else if (rbit_q >= 4'h1 && rbit_q <= 4'h8) begin
          rx_data <= {rxd_s, rx_data[7:1]};
        end else if (rbit_q == 4'h9) begin
          ract_q   <= 1'b0;
          rx_valid <= 1'b1;
          rx_err   <= !rxd_s;
        end
      end
    end
  end

  // transmitter: shifts start, data lsb first, then stop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_busy <= 1'b0;
      txd     <= 1'b1;
      tcnt_q  <= 16'h0000;
      tbit_q  <= 4'h0;
      tsh_q   <= 9'h1FF;
    end else if (!tx_busy) begin
      if (tx_start) begin
        tx_busy <= 1'b1;
        txd     <= 1'b0;
        tsh_q   <= {1'b1, tx_data};
        tbit_q  <= 4'h9;
        tcnt_q  <= div - 16'h0001;
      end
    end else if (tcnt_q != 16'h0000) begin
      tcnt_q <= tcnt_q - 16'h0001;
    end else if (tbit_q == 4'h0) begin
      tx_busy <= 1'b0;
    end else begin
      txd    <= tsh_q[0];
      tsh_q  <= {1'b1, tsh_q[8:1]};
      tbit_q <= tbit_q - 4'h1;
      tcnt_q <= div - 16'h0001;
    end
  end
endmodule

// ==== boot_device.sv ====
// device end of the serial boot loader: probe, commands, RAM transfer
`timescale 1ns/1ns
`include "loader_params.svh"
module boot_device (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  loader_link_if.device            link,
  input  wire logic [95:0]         pwd_ref,
  input  wire logic [15:0]         flash_sum,
  input  wire logic [1:0]          prot_strap,
  output logic                     ram_we,
  output logic [31:0]              ram_addr,
  output logic [7:0]               ram_wdata,
  output logic                     exec_start,
  output logic [31:0]              exec_addr,
  output logic                     erase_start,
  output logic                     prot_set,
  output logic [1:0]               prot_state,
  output logic                     halted
);
  import loader_pkg::*;

  dev_state_t  state_q;
  logic        init_q;
  logic        rx_en_q;
  logic [15:0] div_q;
  logic [16:0] cnt_q;
  logic [3:0]  last_hi_q;
  logic [3:0]  cur_hi_q;
  logic [15:0] idx_q;
  logic [7:0]  sum_q;
  logic        err_q;
  logic        pwd_ok_q;
  logic [47:0] hdr_q;
  logic [31:0] base_q;
  logic [15:0] len_q;
  logic [7:0]  txq_q [0:3];
  logic [2:0]  txn_q;
  logic [1:0]  txp_q;
  logic        tx_go_q;
  logic [7:0]  tx_byte_q;
  logic        rxd_s;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_err;
  logic        tx_busy;
  logic [7:0]  total;
  logic        bad;

  // reply to a finished block: receive error first, then checksum
  function automatic logic [7:0] blk_ack(input logic e, input logic [7:0] t,
                                         input logic p, input logic [3:0] hi);
    if (e)
      blk_ack = {hi, `ACK_RXE_LO};
    else if (t != 8'h00 || !p)
      blk_ack = {hi, `ACK_BAD_LO};
    else
      blk_ack = {hi, `ACK_OK_LO};
  endfunction

  function automatic logic [7:0] pwd_byte(input logic [95:0] r, input logic [3:0] i);
    pwd_byte = r[i*8 +: 8];
  endfunction

  uart_byte_port u_port (
    .core_clk (core_clk),
    .resetn   (resetn),
    .div      (div_q),
    .rx_en    (rx_en_q),
    .rxd      (link.ctl_txd),
    .rxd_s    (rxd_s),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_err   (rx_err),
    .tx_start (tx_go_q),
    .tx_data  (tx_byte_q),
    .tx_busy  (tx_busy),
    .txd      (link.dev_txd)
  );

  // running block sum including this byte, and its error state
  assign total = sum_q + rx_data;
  assign bad   = err_q | rx_err;

  // ----------------------------------------------------------------
  // command interpreter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= D_PROBE;
      init_q      <= 1'b0;
      rx_en_q     <= 1'b0;
      div_q       <= `DIV_MIN;
      cnt_q       <= 17'h00000;
      last_hi_q   <= 4'h0;
      cur_hi_q    <= 4'h0;
      idx_q       <= 16'h0000;
      sum_q       <= 8'h00;
      err_q       <= 1'b0;
      pwd_ok_q    <= 1'b1;
      hdr_q       <= 48'h000000000000;
      base_q      <= 32'h00000000;
      len_q       <= 16'h0000;
      txq_q[0]    <= 8'h00;
      txq_q[1]    <= 8'h00;
      txq_q[2]    <= 8'h00;
      txq_q[3]    <= 8'h00;
      txn_q       <= 3'h0;
      txp_q       <= 2'h0;
      tx_go_q     <= 1'b0;
      tx_byte_q   <= 8'h00;
      ram_we      <= 1'b0;
      ram_addr    <= 32'h00000000;
      ram_wdata   <= 8'h00;
      exec_start  <= 1'b0;
      exec_addr   <= 32'h00000000;
      erase_start <= 1'b0;
      prot_set    <= 1'b0;
      prot_state  <= `PROT_RST;
      halted      <= 1'b0;
    end else begin
      init_q      <= 1'b1;
      tx_go_q     <= 1'b0;
      ram_we      <= 1'b0;
      exec_start  <= 1'b0;
      erase_start <= 1'b0;
      prot_set    <= 1'b0;
      if (!init_q)
        prot_state <= prot_strap; // protection state caught after release
      // drain the reply queue one byte at a time
      if (txn_q != 3'h0 && !tx_busy && !tx_go_q) begin
        tx_go_q   <= 1'b1;
        tx_byte_q <= txq_q[txp_q];
        txp_q     <= txp_q + 2'h1;
        txn_q     <= txn_q - 3'h1;
      end
      unique case (state_q)
        D_PROBE: begin
          if (init_q && !rxd_s) begin
            cnt_q   <= 17'h00001;
            state_q <= D_MEAS;
          end
        end
        D_MEAS: begin
          if (rxd_s) begin
            cnt_q <= 17'h00000;
            if (cnt_q[16:1] < `DIV_MIN || cnt_q[16:1] > `DIV_MAX) begin
              state_q <= D_HALT;
            end else begin
              div_q   <= cnt_q[16:1];
              state_q <= D_TAIL;
            end
          end else if (cnt_q != 17'h1FFFF) begin
            cnt_q <= cnt_q + 17'h00001;
          end
        end
        D_TAIL: begin
          cnt_q <= cnt_q + 17'h00001;
          if (cnt_q[16:3] == {1'b0, div_q[12:0]}) begin
            rx_en_q <= 1'b1;
            state_q <= D_ARM;
          end
        end
        D_ARM: begin
          txq_q[0] <= `PROBE_BYTE;
          txp_q    <= 2'h0;
          txn_q    <= 3'h1;
          state_q  <= D_CMD;
        end
        D_HALT: halted <= 1'b1;
        D_CMD: begin
          if (rx_valid) begin
            txp_q    <= 2'h0;
            txn_q    <= 3'h1;
            idx_q    <= 16'h0000;
            sum_q    <= 8'h00;
            err_q    <= 1'b0;
            pwd_ok_q <= 1'b1;
            cur_hi_q <= rx_data[7:4];
            txq_q[0] <= rx_data;
            if (rx_err) begin
              txq_q[0] <= {last_hi_q, `ACK_RXE_LO};
            end else begin
              unique case (rx_data)
                `CMD_RAM: begin
                  if (prot_state != `PROT_RST) begin
                    txq_q[0] <= {last_hi_q, `ACK_PROT_LO};
                  end else begin
                    last_hi_q <= rx_data[7:4];
                    state_q   <= D_PWD;
                  end
                end
                `CMD_PROT: begin
                  last_hi_q <= rx_data[7:4];
                  state_q   <= D_PWD;
                end
                `CMD_ERASE: begin
                  last_hi_q   <= rx_data[7:4];
                  erase_start <= 1'b1;
                  prot_state  <= `PROT_RST;
                end
                `CMD_SUM: begin
                  last_hi_q <= rx_data[7:4];
                  txq_q[1]  <= flash_sum[15:8];
                  txq_q[2]  <= flash_sum[7:0];
                  txq_q[3]  <= 8'h00 - (flash_sum[15:8] + flash_sum[7:0]);
                  txn_q     <= 3'h4;
                end
                `CMD_INFO: last_hi_q <= rx_data[7:4];
                default: txq_q[0] <= {last_hi_q, `ACK_BAD_LO};
              endcase
            end
          end
        end
        D_PWD: begin
          if (rx_valid) begin
            sum_q <= total;
            err_q <= bad;
            idx_q <= idx_q + 16'h0001;
            if (idx_q < `PWD_LEN) begin
              if (rx_data != pwd_byte(pwd_ref, idx_q[3:0]))
                pwd_ok_q <= 1'b0;
            end else begin
              txq_q[0] <= blk_ack(bad, total, pwd_ok_q, cur_hi_q);
              txp_q    <= 2'h0;
              txn_q    <= 3'h1;
              state_q  <= D_CMD;
              if (blk_ack(bad, total, pwd_ok_q, cur_hi_q) == {cur_hi_q, `ACK_OK_LO}) begin
                idx_q <= 16'h0000;
                sum_q <= 8'h00;
                err_q <= 1'b0;
                if (cur_hi_q == `CMD_RAM >> 4) begin
                  state_q <= D_HDR;
                end else begin
                  prot_state <= `PROT_ALL;
                  prot_set   <= 1'b1;
                end
              end
            end
          end
        end
        D_HDR: begin
          if (rx_valid) begin
            sum_q <= total;
            err_q <= bad;
            idx_q <= idx_q + 16'h0001;
            if (idx_q < `HDR_LEN) begin
              hdr_q <= {hdr_q[39:0], rx_data};
            end else begin
              txq_q[0] <= blk_ack(bad, total, 1'b1, cur_hi_q);
              txp_q    <= 2'h0;
              txn_q    <= 3'h1;
              state_q  <= D_CMD;
              if (!bad && total == 8'h00) begin
                base_q  <= hdr_q[47:16];
                len_q   <= hdr_q[15:0];
                idx_q   <= 16'h0000;
                sum_q   <= 8'h00;
                err_q   <= 1'b0;
                state_q <= D_DATA;
              end
            end
          end
        end
        D_DATA: begin
          if (rx_valid) begin
            sum_q <= total;
            err_q <= bad;
            idx_q <= idx_q + 16'h0001;
            if (idx_q < len_q) begin
              ram_we    <= 1'b1;
              ram_addr  <= base_q + {16'h0000, idx_q};
              ram_wdata <= rx_data;
            end else begin
              txq_q[0] <= blk_ack(bad, total, 1'b1, cur_hi_q);
              txp_q    <= 2'h0;
              txn_q    <= 3'h1;
              state_q  <= D_CMD;
              if (!bad && total == 8'h00) begin
                exec_start <= 1'b1;
                exec_addr  <= base_q;
                state_q    <= D_RUN;
              end
            end
          end
        end
        D_RUN: halted <= 1'b0;
        default: state_q <= D_PROBE;
      endcase
    end
  end
endmodule

// ==== boot_controller.sv ====
// controller end of the serial boot loader: runs one RAM transfer
`timescale 1ns/1ns
`include "loader_params.svh"
module boot_controller #(
  parameter logic [31:0] TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  loader_link_if.controller link,
  input  wire logic        start,
  input  wire logic [95:0] password,
  input  wire logic [31:0] load_addr,
  input  wire logic [15:0] load_len,
  input  wire logic [7:0]  pay_data,
  output logic [15:0]      pay_idx,
  output logic             busy,
  output logic             done,
  output logic             fail,
  output logic [7:0]       last_ack
);
  import loader_pkg::*;

  host_state_t state_q;
  logic [2:0]  ph_q;
  logic [7:0]  sum_q;
  logic [31:0] to_q;
  logic        go_q;
  logic [7:0]  byte_q;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_err;
  logic        tx_busy;
  logic [7:0]  nxt;
  logic        last;
  logic [47:0] hdr;

  uart_byte_port u_port (
    .core_clk (core_clk),
    .resetn   (resetn),
    .div      (16'(`HOST_DIV)),
    .rx_en    (1'b1),
    .rxd      (link.dev_txd),
    .rxd_s    (),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_err   (rx_err),
    .tx_start (go_q),
    .tx_data  (byte_q),
    .tx_busy  (tx_busy),
    .txd      (link.ctl_txd)
  );

  // header block: start address then length, both msb first
  assign hdr = {load_addr, load_len};

  // byte for the current phase and index; checksum closes a block
  always_comb begin
    nxt  = 8'h00 - sum_q;
    last = 1'b1;
    unique case (ph_q)
      3'h0: nxt = `PROBE_BYTE;
      3'h1: nxt = `CMD_RAM;
      3'h2: begin
        last = (pay_idx == `PWD_LEN);
        if (!last)
          nxt = password[pay_idx[3:0]*8 +: 8];
      end
      3'h3: begin
        last = (pay_idx == `HDR_LEN);
        if (!last)
          nxt = hdr[(5 - pay_idx[2:0])*8 +: 8];
      end
      default: begin
        last = (pay_idx == load_len);
        if (!last)
          nxt = pay_data;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= H_IDLE;
      ph_q     <= 3'h0;
      sum_q    <= 8'h00;
      to_q     <= 32'h00000000;
      go_q     <= 1'b0;
      byte_q   <= 8'h00;
      pay_idx  <= 16'h0000;
      busy     <= 1'b0;
      done     <= 1'b0;
      fail     <= 1'b0;
      last_ack <= 8'h00;
    end else begin
      go_q <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          if (start) begin
            done    <= 1'b0;
            fail    <= 1'b0;
            ph_q    <= 3'h0;
            sum_q   <= 8'h00;
            pay_idx <= 16'h0000;
            if (load_addr < `RAM_LO || load_addr + {16'h0000, load_len} > `RAM_HI + 32'h00000001) begin
              done <= 1'b1;
              fail <= 1'b1;
            end else begin
              busy    <= 1'b1;
              state_q <= H_SEND;
            end
          end
        end
        H_SEND: begin
          if (!tx_busy && !go_q) begin
            go_q   <= 1'b1;
            byte_q <= nxt;
            sum_q  <= sum_q + nxt;
            to_q   <= 32'h00000000;
            if (last)
              state_q <= H_WAIT;
            else
              pay_idx <= pay_idx + 16'h0001;
          end
        end
        H_WAIT: begin
          to_q <= to_q + 32'h00000001;
          if (rx_valid) begin
            last_ack <= rx_data;
            pay_idx  <= 16'h0000;
            sum_q    <= 8'h00;
            ph_q     <= ph_q + 3'h1;
            state_q  <= H_SEND;
            if (rx_err || rx_data != (ph_q == 3'h0 ? `PROBE_BYTE : `CMD_RAM)) begin
              state_q <= H_IDLE;
              busy    <= 1'b0;
              done    <= 1'b1;
              fail    <= 1'b1;
            end else if (ph_q == 3'h4) begin
              state_q <= H_IDLE;
              busy    <= 1'b0;
              done    <= 1'b1;
            end
          end else if (to_q >= TIMEOUT_CYCLES - 32'h00000001) begin
            state_q <= H_IDLE;
            busy    <= 1'b0;
            done    <= 1'b1;
            fail    <= 1'b1;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end
endmodule

// ==== loader_link_assertions.sv ====
// link-level checks on the serial line between controller and device
`timescale 1ns/1ns
`include "loader_params.svh"
module loader_link_assertions (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ctl_txd,
  input wire logic dev_txd
);
  logic [11:0] clow_q;
  logic [11:0] dlow_q;
  logic        seen_q;
  logic [12:0] pw_q;     // cycles since the probe began
  logic        pw_on_q;  // probe under way, reply not yet begun

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  // low-run lengths of both lines, and whether the first frame has begun
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clow_q <= 12'h000;
      dlow_q <= 12'h000;
      seen_q <= 1'b0;
      pw_q    <= 13'h0000;
      pw_on_q <= 1'b0;
    end else begin
      clow_q <= ctl_txd ? 12'h000 : clow_q + 12'h001;
      dlow_q <= dev_txd ? 12'h000 : dlow_q + 12'h001;
      seen_q <= seen_q | ~ctl_txd;
      // time the probe-to-reply gap with a counter, not a long delay range
      if (!seen_q && !ctl_txd) begin
        pw_on_q <= 1'b1;
        pw_q    <= 13'h0000;
      end else if (pw_on_q) begin
        pw_on_q <= dev_txd;
        pw_q    <= pw_q + 13'h0001;
      end
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_waiting;
    pw_on_q;
  endsequence
  sequence s_reply;
    $fell(dev_txd);
  endsequence

  AST_PROBE_REPLY: assert property ((s_waiting ##0 s_reply) |-> pw_q >= 9 * `HOST_DIV)
    else $error("probe reply began before the probe frame ended");
  AST_PROBE_DEADLINE: assert property (s_waiting |-> pw_q <= 20 * `HOST_DIV)
    else $error("probe byte drew no reply frame");
  AST_CTL_LOW_RUN: assert property ($rose(ctl_txd) |-> clow_q % `HOST_DIV == 0 && clow_q <= 9 * `HOST_DIV)
    else $error("controller low run is not whole bits");
  AST_CTL_HIGH_RUN: assert property ($rose(ctl_txd) |-> ctl_txd [*8])
    else $error("controller high run too short");
  AST_DEV_HIGH_RUN: assert property ($rose(dev_txd) |-> dev_txd [*8])
    else $error("device high run too short");
  AST_DEV_LOW_RUN: assert property ($rose(dev_txd) |-> dlow_q >= `HOST_DIV - 8 && dlow_q <= 9 * `HOST_DIV + 8)
    else $error("device low run out of frame bounds");
  AST_DEV_WAITS: assert property ($fell(dev_txd) |-> ctl_txd)
    else $error("device began a reply during a controller frame");
  AST_CTL_WAITS: assert property ($fell(ctl_txd) |-> dev_txd)
    else $error("controller sent during a device reply");
  AST_DEV_SILENT: assert property ($rose(resetn) |-> dev_txd [*8])
    else $error("device line not idle after reset");
endmodule

// ==== serial_boot_ram_loader_bench.sv ====
// self-checking bench: controller and device joined over one serial link
`timescale 1ns/1ns
`include "loader_params.svh"
module serial_boot_ram_loader_bench;
  typedef struct {
    logic [1:0]  prot;
    logic        bad;
    logic [31:0] addr;
    logic [15:0] len;
    logic        fail;
    logic [7:0]  ack;
  } row_t;
  localparam logic [95:0] PWD = 96'hC3B2A1908F7E6D5C4B3A2918;
  logic        core_clk   = 1'b0;
  logic        resetn;
  logic        start      = 1'b0;
  logic [1:0]  prot_strap = 2'h0;
  logic [7:0]  pay_data;
  logic [15:0] pay_idx;
  logic        busy, done, fail, ram_we, exec_start, halted;
  logic [7:0]  last_ack, ram_wdata;
  logic [31:0] ram_addr, exec_addr;
  logic [1:0]  prot_state;
  logic [7:0]  cq[$];
  logic [7:0]  dq[$];
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  int          nw         = 0;
  int          nx         = 0;
  row_t        rows[5];
  row_t        r;

  loader_link_if link ();
  boot_device u_boot_device (.core_clk(core_clk), .resetn(resetn), .link(link.device), .pwd_ref(PWD),
    .flash_sum(16'h1234), .prot_strap(prot_strap), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .exec_start(exec_start), .exec_addr(exec_addr), .erase_start(), .prot_set(), .prot_state(prot_state),
    .halted(halted));
  boot_controller #(.TIMEOUT_CYCLES(32'h00004E20)) u_boot_controller (.core_clk(core_clk), .resetn(resetn),
    .link(link.controller), .start(start), .password(r.bad ? ~PWD : PWD), .load_addr(r.addr), .load_len(r.len),
    .pay_data(pay_data), .pay_idx(pay_idx), .busy(busy), .done(done), .fail(fail), .last_ack(last_ack));
  loader_link_assertions u_loader_link_assertions (.core_clk(core_clk), .resetn(resetn),
    .ctl_txd(link.ctl_txd), .dev_txd(link.dev_txd));

  // payload byte k is A0H plus k
  assign pay_data = 8'hA0 + pay_idx[7:0];

  // ----------------------------------------
  // clock, timeout, ram watch
  // ----------------------------------------
  always #20 core_clk = ~core_clk;

  always @(negedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      report_and_stop();
    end
    if (ram_we === 1'b1) begin
      chk(ram_addr, r.addr + nw, "ram addr");
      chk(ram_wdata, 8'hA0 + nw[7:0], "ram data");
      nw++;
    end
    if (exec_start === 1'b1) begin
      chk(exec_addr, r.addr, "exec addr");
      nx++;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic line_of(input bit dev);
    return dev ? link.dev_txd : link.ctl_txd;
  endfunction

  function automatic logic [7:0] sum(input int a, input int b);
    logic [7:0] s = 8'h00;
    for (int i = a; i <= b; i++) s += cq[i];
    return s;
  endfunction

  // decode frames off one line, lsb first, at the host bit time
  task automatic mon(input bit dev);
    logic [7:0] b;
    forever begin
      @(negedge core_clk);
      if (line_of(dev) === 1'b0) begin
        repeat (`HOST_DIV / 2) @(negedge core_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (`HOST_DIV) @(negedge core_clk);
          b[i] = line_of(dev);
        end
        repeat (`HOST_DIV) @(negedge core_clk);
        chk(line_of(dev), 1, "stop bit");
        if (dev) dq.push_back(b);
        else cq.push_back(b);
      end
    end
  endtask

  task automatic do_reset();
    @(negedge core_clk);
    resetn = 1'b0;
    prot_strap = r.prot;
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    cq.delete();
    dq.delete();
    nw = 0;
    nx = 0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rows[0] = '{2'h1, 1'b0, 32'h1DFF, 16'h1, 1'b1, 8'h06};
    rows[1] = '{2'h0, 1'b1, 32'h1DFF, 16'h1, 1'b1, 8'h11};
    rows[2] = '{2'h0, 1'b0, 32'h0FFF, 16'h1, 1'b1, 8'h00};
    rows[3] = '{2'h0, 1'b0, 32'h1DFF, 16'h2, 1'b1, 8'h00};
    rows[4] = '{2'h0, 1'b0, 32'h1DFF, 16'h1, 1'b0, 8'h10};
    r = rows[4];
    fork
      mon(1'b0);
      mon(1'b1);
    join_none
    foreach (rows[k]) begin
      r = rows[k];
      do_reset();
      start = 1'b1;
      @(negedge core_clk);
      start = 1'b0;
      for (int w = 0; w < 70000 && done !== 1'b1; w++) @(negedge core_clk);
      repeat (400) @(negedge core_clk);
      chk(fail, r.fail, "fail");
      chk(last_ack, r.ack, "last ack");
      chk(halted, 0, "halted");
      chk(nw, r.fail ? 0 : r.len, "writes");
      chk(nx, !r.fail, "exec");
      if (r.ack != 8'h00) begin
        chk(cq[0], 8'h86, "probe");
        chk(dq[0], 8'h86, "probe reply");
        chk(cq[1], 8'h10, "command");
        chk(dq[1], r.prot != 0 ? 8'h06 : 8'h10, "command ack");
      end
      if (!r.fail) begin
        chk(cq.size(), 24, "sent bytes");
        for (int i = 0; i < 12; i++) chk(cq[2 + i], PWD[8 * i +: 8], "password");
        chk(sum(2, 14), 0, "password sum");
        for (int i = 0; i < 4; i++) chk(cq[15 + i], r.addr[31 - 8 * i -: 8], "address");
        chk({cq[19], cq[20]}, r.len, "length");
        chk(sum(15, 21), 0, "header sum");
        chk(sum(22, 23), 0, "payload sum");
        for (int i = 2; i < 5; i++) chk(dq[i], 8'h10, "block ack");
      end
      $display("row %0d done", k);
    end
    // second reset in the middle of a transfer
    do_reset();
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    repeat (5000) @(negedge core_clk);
    do_reset();
    chk({busy, done, fail, halted, prot_state, last_ack}, 0, "after reset");
    chk({link.ctl_txd, link.dev_txd}, 2'h3, "idle lines");
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule
